//--- design/latch_ack_pkg.sv
package latch_ack_pkg;

  // ----------------------------------------------------------------
  // Timing constants
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 125_000_000;
  localparam int unsigned LONG_PRESS_MS   = 1000;
  localparam int unsigned LED_TEST_MS     = 1000;
  localparam int unsigned LONG_PRESS_CYC  = CLK_HZ / 1000 * LONG_PRESS_MS;
  localparam int unsigned LED_TEST_CYC    = CLK_HZ / 1000 * LED_TEST_MS;
  localparam int unsigned OFF_DELAY_RESET = 0;

  // ----------------------------------------------------------------
  // Panel long-press category sets
  // ----------------------------------------------------------------
  localparam logic [2:0] KEY_NOTHING     = 3'h0;
  localparam logic [2:0] KEY_LED_NOPW    = 3'h1;
  localparam logic [2:0] KEY_LED         = 3'h2;
  localparam logic [2:0] KEY_LED_RELAY   = 3'h3;
  localparam logic [2:0] KEY_EVERYTHING  = 3'h4;
  localparam logic [2:0] KEY_SET_RESET   = KEY_LED_NOPW;

  typedef enum logic [1:0] {
    TEST_IDLE,
    TEST_RED,
    TEST_GREEN
  } led_test_t;

  // Collective acknowledge commands from the supervisory link or software.
  typedef struct packed {
    logic allLed;
    logic allOutput;
    logic allScada;
    logic allTrip;
  } collective_cmd_t;

  // LED test drive to the panel.
  typedef struct packed {
    logic flashRed;
    logic flashGreen;
  } led_test_out_t;

endpackage

//--- design/output_off_delay.sv
module output_off_delay #(
  parameter int unsigned CNT_W = 32
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // Control
  input  wire logic             ackPending,
  input  wire logic [CNT_W-1:0] offDelayCycles,
  input  wire logic             outputActive,
  // Result
  output logic                  expired
);

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic             running;
    logic             expired;
  } off_state_t;

  off_state_t stateReg;
  off_state_t stateNext;

  // ----------------------------------------------------------------
  // Off-delay timer: restarts while the output is still active.
  // ----------------------------------------------------------------
  always_comb begin
    stateNext         = stateReg;
    stateNext.expired = 1'b0;
    if (outputActive || !ackPending) begin
      stateNext.count   = '0;
      stateNext.running = 1'b0;
    end else if (stateReg.count >= offDelayCycles) begin
      stateNext.expired = 1'b1;
      stateNext.count   = '0;
      stateNext.running = 1'b0;
    end else begin
      stateNext.running = 1'b1;
      stateNext.count   = stateReg.count + CNT_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      stateReg <= '0;
    end else begin
      stateReg <= stateNext;
    end
  end

  assign expired = stateReg.expired;

endmodule

//--- design/latch_acknowledge_logic.sv
// Summary of operation
// - A latch clears only after its initiating signal has gone inactive.
// - Without remote permission only the panel key acknowledges anything.
// - Output latches release only after that output's off-delay expires.
// - Each LED has its own acknowledge input clearing that LED only.
// - Each binary output has its own acknowledge input clearing that output.
// - Group acknowledge inputs are disabled without remote permission.
// - Supervisory link acknowledges are rejected without remote permission.
// - Auto-ack LEDs clear on a new protection alarm; LEDs only.
// - Panel key held one second acknowledges the configured category set.
// - An LED acknowledge with that LED's initiating signal inactive runs a test: red one second, then green.
module latch_acknowledge_logic #(
  parameter int unsigned NUM_LED      = 16,
  parameter int unsigned NUM_OUT      = 8,
  parameter int unsigned NUM_SCADA    = 8,
  parameter int unsigned NUM_TRIP     = 4,
  parameter int unsigned CNT_W        = 32,
  parameter int unsigned LONG_PRESS   = latch_ack_pkg::LONG_PRESS_CYC,
  parameter int unsigned LED_TEST_LEN = latch_ack_pkg::LED_TEST_CYC
) (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        srst,
  // Configuration
  input  wire logic                        remoteAckEnable,
  input  wire logic [2:0]                  keyAckSet,
  input  wire logic [NUM_LED-1:0]          ledAutoAck,
  input  wire logic [CNT_W-1:0]            offDelayCycles,
  // Panel key, asynchronous pin
  input  wire logic                        clearKeyPin,
  // Initiating signals
  input  wire logic [NUM_LED-1:0]          ledSetSig,
  input  wire logic [NUM_OUT-1:0]          outSetSig,
  input  wire logic [NUM_SCADA-1:0]        scadaSetSig,
  input  wire logic [NUM_TRIP-1:0]         tripSetSig,
  // Acknowledge sources
  input  wire logic [NUM_LED-1:0]          ledAckSource,
  input  wire logic [NUM_OUT-1:0]          outputAckSource,
  input  wire logic                        all_led_ack_source,
  input  wire logic                        all_output_ack_source,
  input  wire logic                        scadaAckSource,
  input  wire logic [NUM_TRIP-1:0]         trip_command_ack_source,
  input  wire latch_ack_pkg::collective_cmd_t linkCmd,
  input  wire latch_ack_pkg::collective_cmd_t softCmd,
  input  wire logic                        protAlarm,
  // Latched state
  output logic [NUM_LED-1:0]               ledLatch,
  output logic [NUM_OUT-1:0]               outLatch,
  output logic [NUM_SCADA-1:0]             scadaLatch,
  output logic [NUM_TRIP-1:0]              tripLatch,
  output latch_ack_pkg::led_test_out_t     ledTest
);

  localparam int unsigned SRC_W = NUM_LED + NUM_OUT + NUM_TRIP + 12;

  typedef struct packed {
    logic [1:0]           keySync;
    logic [CNT_W-1:0]     keyCount;
    logic                 keyFired;
    logic [SRC_W-1:0]     srcPrev;
    logic [NUM_LED-1:0]   led;
    logic [NUM_OUT-1:0]   out;
    logic [NUM_OUT-1:0]   outAckPend;
    logic [NUM_SCADA-1:0] scada;
    logic [NUM_TRIP-1:0]  trip;
    latch_ack_pkg::led_test_t testState;
    logic [CNT_W-1:0]     testCount;
    latch_ack_pkg::led_test_out_t testOut;
  } state_t;

  state_t stateReg;
  state_t stateNext;

  logic [SRC_W-1:0]   srcNow;
  logic [SRC_W-1:0]   srcRise;
  logic [NUM_OUT-1:0] outRelease;

  // ----------------------------------------------------------------
  // Edge detection of every acknowledge source.
  // ----------------------------------------------------------------
  // Low twelve bits: group sources at 11..9, alarm at 8, link at 7..4, software at 3..0.
  assign srcNow  = {ledAckSource, outputAckSource, trip_command_ack_source,
                    all_led_ack_source, all_output_ack_source, scadaAckSource,
                    protAlarm, linkCmd, softCmd};
  assign srcRise = srcNow & ~stateReg.srcPrev;

  // ----------------------------------------------------------------
  // Per-output off-delay timers.
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NUM_OUT; i++) begin : gOut
    output_off_delay #(
      .CNT_W (CNT_W)
    ) u_output_off_delay (
      .clk            (clk),
      .srst           (srst),
      .ackPending     (stateReg.outAckPend[i]),
      .offDelayCycles (offDelayCycles),
      .outputActive   (outSetSig[i]),
      .expired        (outRelease[i])
    );
  end

  // ----------------------------------------------------------------
  // Acknowledge decision and latches.
  // ----------------------------------------------------------------
  always_comb begin
    logic                 keyLed;
    logic                 keyOut;
    logic                 keyAll;
    logic                 remLed;
    logic                 remOut;
    logic                 remScada;
    logic                 remTrip;
    logic                 autoAck;
    logic [NUM_LED-1:0]   ledAck;
    logic [NUM_OUT-1:0]   outAck;
    logic [NUM_TRIP-1:0]  tripAck;
    logic                 scadaAck;
    keyLed   = 1'b0;
    keyOut   = 1'b0;
    keyAll   = 1'b0;
    remLed   = 1'b0;
    remOut   = 1'b0;
    remScada = 1'b0;
    remTrip  = 1'b0;
    autoAck  = 1'b0;
    ledAck   = '0;
    outAck   = '0;
    tripAck  = '0;
    scadaAck = 1'b0;
    stateNext = stateReg;
    stateNext.keySync = {stateReg.keySync[0], clearKeyPin};
    stateNext.srcPrev = srcNow;

    // Long press of the panel key fires once per press.
    if (!stateReg.keySync[1]) begin
      stateNext.keyCount = '0;
      stateNext.keyFired = 1'b0;
    end else if (!stateReg.keyFired) begin
      if (stateReg.keyCount >= CNT_W'(LONG_PRESS - 1)) begin
        stateNext.keyFired = 1'b1;
        case (keyAckSet)
          latch_ack_pkg::KEY_LED_NOPW,
          latch_ack_pkg::KEY_LED: begin
            keyLed = 1'b1;
          end
          latch_ack_pkg::KEY_LED_RELAY: begin
            keyLed = 1'b1;
            keyOut = 1'b1;
          end
          latch_ack_pkg::KEY_EVERYTHING: begin
            keyLed = 1'b1;
            keyOut = 1'b1;
            keyAll = 1'b1;
          end
          default: begin
            keyLed = 1'b0;
          end
        endcase
      end else begin
        stateNext.keyCount = stateReg.keyCount + CNT_W'(1);
      end
    end

    // Non-panel sources pass only with remote permission.
    remLed   = remoteAckEnable & (srcRise[11] | srcRise[7] | srcRise[3]);
    remOut   = remoteAckEnable & (srcRise[10] | srcRise[6] | srcRise[2]);
    remScada = remoteAckEnable & (srcRise[9] | srcRise[5] | srcRise[1]);
    remTrip  = remoteAckEnable & (srcRise[4] | srcRise[0]);
    autoAck  = remoteAckEnable & srcRise[8];

    ledAck   = srcRise[SRC_W-1 -: NUM_LED] & {NUM_LED{remoteAckEnable}};
    ledAck   = ledAck | {NUM_LED{remLed | keyLed}};
    ledAck   = ledAck | (ledAutoAck & {NUM_LED{autoAck}});
    outAck   = srcRise[SRC_W-1-NUM_LED -: NUM_OUT] & {NUM_OUT{remoteAckEnable}};
    outAck   = outAck | {NUM_OUT{remOut | keyOut}};
    tripAck  = srcRise[SRC_W-1-NUM_LED-NUM_OUT -: NUM_TRIP] & {NUM_TRIP{remoteAckEnable}};
    tripAck  = tripAck | {NUM_TRIP{remTrip | keyAll}};
    scadaAck = remScada | keyAll;

    // Latch set by initiating signal; clear only once that signal is gone.
    stateNext.led   = (stateReg.led | ledSetSig) & ~(ledAck & ~ledSetSig);
    stateNext.scada = (stateReg.scada | scadaSetSig) &
                      ~({NUM_SCADA{scadaAck}} & ~scadaSetSig);
    stateNext.trip  = (stateReg.trip | tripSetSig) & ~(tripAck & ~tripSetSig);
    stateNext.outAckPend = (stateReg.outAckPend | (outAck & ~outSetSig & stateReg.out))
                           & ~outRelease & ~outSetSig;
    stateNext.out   = (stateReg.out & ~outRelease) | outSetSig;

    // LED test after an LED acknowledge whose initiating signal is inactive.
    case (stateReg.testState)
      latch_ack_pkg::TEST_IDLE: begin
        stateNext.testOut = '0;
        if (|(ledAck & ~ledSetSig)) begin
          stateNext.testState         = latch_ack_pkg::TEST_RED;
          stateNext.testCount         = '0;
          stateNext.testOut.flashRed  = 1'b1;
        end
      end
      latch_ack_pkg::TEST_RED: begin
        stateNext.testCount = stateReg.testCount + CNT_W'(1);
        if (stateReg.testCount >= CNT_W'(LED_TEST_LEN - 1)) begin
          stateNext.testState          = latch_ack_pkg::TEST_GREEN;
          stateNext.testCount          = '0;
          stateNext.testOut.flashRed   = 1'b0;
          stateNext.testOut.flashGreen = 1'b1;
        end
      end
      latch_ack_pkg::TEST_GREEN: begin
        stateNext.testCount = stateReg.testCount + CNT_W'(1);
        if (stateReg.testCount >= CNT_W'(LED_TEST_LEN - 1)) begin
          stateNext.testState = latch_ack_pkg::TEST_IDLE;
          stateNext.testOut   = '0;
        end
      end
      default: begin
        stateNext.testState = latch_ack_pkg::TEST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      stateReg <= '0;
    end else begin
      stateReg <= stateNext;
    end
  end

  assign ledLatch   = stateReg.led;
  assign outLatch   = stateReg.out;
  assign scadaLatch = stateReg.scada;
  assign tripLatch  = stateReg.trip;
  assign ledTest    = stateReg.testOut;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_led_hold_active: assert property (@(posedge clk) disable iff (srst)
    ledSetSig[0] |=> ledLatch[0])
    else $error("LED latch cleared while its initiating signal was active");
  chk_trip_hold_active: assert property (@(posedge clk) disable iff (srst)
    tripSetSig[0] |=> tripLatch[0])
    else $error("Trip latch cleared while its initiating signal was active");
  chk_remote_blocked: assert property (@(posedge clk) disable iff (srst)
    (!remoteAckEnable && !stateReg.keySync[1] && !stateReg.keyFired && scadaLatch[0])
    |=> scadaLatch[0])
    else $error("Scada latch cleared without remote permission");
  chk_group_led_blocked: assert property (@(posedge clk) disable iff (srst)
    (!remoteAckEnable && !stateReg.keySync[1] && ledLatch[0]) |=> ledLatch[0])
    else $error("LED latch cleared by a remote source without permission");
  chk_link_blocked: assert property (@(posedge clk) disable iff (srst)
    (!remoteAckEnable && !stateReg.keySync[1] && tripLatch[0]) |=> tripLatch[0])
    else $error("Trip latch cleared by the link without permission");
  chk_out_needs_delay: assert property (@(posedge clk) disable iff (srst)
    (outLatch[0] && !outRelease[0]) |=> outLatch[0])
    else $error("Output latch released before off-delay elapsed");
  chk_single_led_ack: assert property (@(posedge clk) disable iff (srst)
    (remoteAckEnable && $rose(ledAckSource[0]) && ledLatch[0] && !ledSetSig[0])
    |=> !ledLatch[0])
    else $error("Individual LED acknowledge did not clear its LED");
  chk_auto_led_ack: assert property (@(posedge clk) disable iff (srst)
    (remoteAckEnable && $rose(protAlarm) && ledAutoAck[0] && !ledSetSig[0])
    |=> !ledLatch[0])
    else $error("Auto acknowledge did not clear the LED");
  chk_test_sequence: assert property (@(posedge clk) disable iff (srst)
    $rose(ledTest.flashGreen) |-> $past(ledTest.flashRed))
    else $error("Green LED test phase not preceded by red");

  cov_key_ack: cover property (@(posedge clk) disable iff (srst) $rose(stateReg.keyFired));
  cov_out_release: cover property (@(posedge clk) disable iff (srst) outRelease[0]);
  cov_led_test: cover property (@(posedge clk) disable iff (srst) $rose(ledTest.flashRed));

endmodule

//--- tb/panel_key_model.sv
module panel_key_model (
  // Clock
  input  wire logic       clk,
  // Command from the bench
  input  wire logic       keyStart,
  input  wire logic [7:0] holdCycles,
  // Key contact
  output logic            clearKeyPin
);
  timeunit 1ns;
  timeprecision 1ps;

  // -------------------------------------------------------
  // Operator press
  // -------------------------------------------------------
  // The key is held for a chosen number of cycles, then released to its open level.
  initial begin
    clearKeyPin = 1'b0;
    forever begin
      @(posedge keyStart);
      clearKeyPin = 1'b1;
      repeat (holdCycles) @(negedge clk);
      clearKeyPin = 1'b0;
    end
  end
endmodule

//--- tb/test_latch_acknowledge_logic.sv
module test_latch_acknowledge_logic;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned LT = 8;

  logic                           clk, srst, remoteAckEnable, clearKeyPin, keyStart;
  logic                           allLedAck, allOutAck, scadaAck, protAlarm;
  logic [2:0]                     keyAckSet;
  logic [7:0]                     holdCycles;
  logic [3:0]                     ledAutoAck, ledSet, ledAck, ledLatch;
  logic [1:0]                     outSet, scadaSet, tripSet, outAck, tripAck;
  logic [1:0]                     outLatch, scadaLatch, tripLatch;
  logic [31:0]                    offDelay;
  latch_ack_pkg::collective_cmd_t linkCmd, softCmd;
  latch_ack_pkg::led_test_out_t   ledTest;
  int                             num_errors, samples_checked;

  latch_acknowledge_logic #(.NUM_LED(4), .NUM_OUT(2), .NUM_SCADA(2), .NUM_TRIP(2),
    .CNT_W(32), .LONG_PRESS(8), .LED_TEST_LEN(LT)) u_latch_acknowledge_logic (
    .clk(clk), .srst(srst), .remoteAckEnable(remoteAckEnable), .keyAckSet(keyAckSet),
    .ledAutoAck(ledAutoAck), .offDelayCycles(offDelay), .clearKeyPin(clearKeyPin),
    .ledSetSig(ledSet), .outSetSig(outSet), .scadaSetSig(scadaSet), .tripSetSig(tripSet),
    .ledAckSource(ledAck), .outputAckSource(outAck), .all_led_ack_source(allLedAck),
    .all_output_ack_source(allOutAck), .scadaAckSource(scadaAck),
    .trip_command_ack_source(tripAck), .linkCmd(linkCmd), .softCmd(softCmd),
    .protAlarm(protAlarm), .ledLatch(ledLatch), .outLatch(outLatch),
    .scadaLatch(scadaLatch), .tripLatch(tripLatch), .ledTest(ledTest));

  panel_key_model u_panel_key_model (
    .clk(clk), .keyStart(keyStart), .holdCycles(holdCycles), .clearKeyPin(clearKeyPin));

  always #4 clk = ~clk;

  // -------------------------------------------------------
  // Helpers
  // -------------------------------------------------------
  task results;
    if (num_errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task chk(input logic [3:0] got, input logic [3:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  task setAll;
    {ledSet, outSet, scadaSet, tripSet} = 10'h3FF;
    tick(1);
    {ledSet, outSet, scadaSet, tripSet} = 10'h000;
    tick(1);
  endtask

  task press(input logic [7:0] n);
    holdCycles = n;
    keyStart = 1'b1;
    tick(1);
    keyStart = 1'b0;
    tick(n + 30);
  endtask

  // -------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------
  task ledSingle;
    setAll();
    ledSet = 4'h2;
    ledAck = 4'h2;
    tick(1);
    ledAck = 4'h0;
    tick(2);
    chk(ledLatch, 4'hF);
    ledSet = 4'h0;
    tick(1);
    ledAck = 4'h2;
    tick(1);
    ledAck = 4'h0;
    tick(1);
    chk(ledLatch, 4'hD);
    chk({2'h0, ledTest}, 4'h2);
    tick(LT);
    chk({2'h0, ledTest}, 4'h1);
    tick(LT + 2);
    chk({2'h0, ledTest}, 4'h0);
  endtask

  task noPermission;
    int k;
    remoteAckEnable = 1'b0;
    ledAutoAck = 4'hF;
    setAll();
    {allLedAck, allOutAck, scadaAck, protAlarm} = 4'hF;
    {ledAck, outAck, tripAck, linkCmd, softCmd} = 16'hFFFF;
    tick(1);
    {allLedAck, allOutAck, scadaAck, protAlarm} = 4'h0;
    {ledAck, outAck, tripAck, linkCmd, softCmd} = 16'h0000;
    tick(30);
    chk(ledLatch, 4'hF);
    chk({outLatch, scadaLatch}, 4'hF);
    chk({2'h0, tripLatch}, 4'h3);
    keyAckSet = 3'h4;
    press(4);
    chk(ledLatch, 4'hF);
    ledAutoAck = 4'h0;
    for (k = 0; k < 5; k++) begin
      setAll();
      keyAckSet = k[2:0];
      press(14);
      chk(ledLatch, (k >= 1) ? 4'h0 : 4'hF);
      chk({outLatch, scadaLatch}, {(k >= 3) ? 2'h0 : 2'h3, (k == 4) ? 2'h0 : 2'h3});
      chk({2'h0, tripLatch}, (k == 4) ? 4'h0 : 4'h3);
    end
    remoteAckEnable = 1'b1;
  endtask

  task outputDelay;
    int i;
    offDelay = 32'h0000_000C;
    outSet = 2'h3;
    tick(1);
    outSet = 2'h0;
    outAck = 2'h1;
    tick(1);
    outAck = 2'h0;
    tick(10);
    chk({2'h0, outLatch}, 4'h3);
    for (i = 10; i < 40 && outLatch[0] !== 1'b0; i++)
      tick(1);
    chk({2'h0, outLatch}, 4'h2);
    chk({3'h0, (i > 12) && (i <= 15)}, 4'h1);
  endtask

  task autoAndGroup;
    setAll();
    ledAutoAck = 4'h1;
    protAlarm = 1'b1;
    tick(1);
    protAlarm = 1'b0;
    tick(30);
    chk(ledLatch, 4'hE);
    chk({2'h0, outLatch}, 4'h3);
    ledAutoAck = 4'h0;
    tripAck = 2'h2;
    linkCmd.allScada = 1'b1;
    {allLedAck, allOutAck} = 2'h3;
    tick(1);
    tripAck = 2'h0;
    linkCmd.allScada = 1'b0;
    {allLedAck, allOutAck} = 2'h0;
    tick(30);
    chk({tripLatch, scadaLatch}, 4'h4);
    chk({ledLatch[1:0], outLatch}, 4'h0);
    setAll();
    softCmd = 4'hF;
    scadaAck = 1'b1;
    tick(1);
    softCmd = 4'h0;
    scadaAck = 1'b0;
    tick(30);
    chk(ledLatch, 4'h0);
    chk({outLatch, scadaLatch}, 4'h0);
    chk({2'h0, tripLatch}, 4'h0);
  endtask

  // -------------------------------------------------------
  // Main sequence and watchdog
  // -------------------------------------------------------
  initial begin
    clk = 1'b0;
    srst = 1'b1;
    remoteAckEnable = 1'b1;
    {keyStart, allLedAck, allOutAck, scadaAck, protAlarm} = 5'h00;
    {keyAckSet, holdCycles, ledAutoAck, ledSet, ledAck} = 23'h000000;
    {outSet, scadaSet, tripSet, outAck, tripAck} = 10'h000;
    {linkCmd, softCmd} = 8'h00;
    offDelay = 32'h0000_0014;
    num_errors = 0;
    samples_checked = 0;
    tick(16);
    srst = 1'b0;
    tick(1);
    chk(ledLatch, 4'h0);
    ledSingle();
    noPermission();
    outputDelay();
    autoAndGroup();
    results();
  end

  initial begin
    tick(20000);
    num_errors++;
    results();
  end
endmodule
